/* File: core/aicr_ctl.sv */
// firmware-side controller: apb registers that drive the clock and reset block
module aicr_ctl
    import aicr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    aicr_if.ctl              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             shared_irq_line,
    output logic             core_reset_n
);
    import aicr_pkg::*;

    // all state of the controller
    typedef struct packed {
        logic        pready;            // one-cycle access answer
        logic [31:0] prdata;
        logic        pslverr;
        logic        cmd_wr;            // one-cycle command strobe
        logic [1:0]  cmd_sel;
        logic [31:0] cmd_data;
        logic [17:0] gcfg;              // copy of the gpio setup
        logic        irq;
        logic        rst_n;
    } aicr_ctl_state_t;

    aicr_ctl_state_t q;                 // registered state
    aicr_ctl_state_t d;                 // next state

    // next-state logic
    always_comb
    begin
        logic access;
        access    = psel && penable && !q.pready;
        d         = q;
        d.pready  = access;
        d.pslverr = 1'b0;
        d.prdata  = 32'h0000_0000;
        d.cmd_wr  = 1'b0;
        if (access && pwrite)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    // refuse a switch while an image is being copied
                    if (link.clk_cfg[CC_LOADING])
                    begin
                        d.pslverr = 1'b1;
                    end
                    else
                    begin
                        d.cmd_wr   = 1'b1;
                        d.cmd_sel  = CMD_CLKCFG;
                        d.cmd_data = pwdata;
                    end
                end
                OFS_GPIO_CFG:
                begin
                    d.cmd_wr   = 1'b1;
                    d.cmd_sel  = CMD_GPIOCFG;
                    d.cmd_data = pwdata;
                    d.gcfg     = pwdata[17:0];
                end
                OFS_ACK:
                begin
                    d.cmd_wr   = 1'b1;
                    d.cmd_sel  = CMD_ACK;
                    d.cmd_data = pwdata;
                end
                default:
                begin
                    d.pslverr = 1'b1;                   // status, gpio pending and unmapped
                end
            endcase
        end
        else if (access)
        begin
            case (paddr)
                OFS_CTRL:      d.prdata = {30'h0000_0000, link.clk_cfg[1:0]};
                OFS_STATUS:    d.prdata = {24'h00_0000, link.clk_cfg};
                OFS_GPIO_CFG:  d.prdata = {14'h0000, q.gcfg};
                OFS_GPIO_PEND: d.prdata = {26'h000_0000, link.gpio_pend};
                default:       d.pslverr = !(paddr == OFS_ACK);
            endcase
        end
        d.irq   = link.irq;
        d.rst_n = link.sys_rst_n;
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign pready          = q.pready;
    assign prdata          = q.prdata;
    assign pslverr         = q.pslverr;
    assign link.cmd_wr     = q.cmd_wr;
    assign link.cmd_sel    = q.cmd_sel;
    assign link.cmd_data   = q.cmd_data;
    assign shared_irq_line = q.irq;
    assign core_reset_n    = q.rst_n;
endmodule // aicr_ctl

/* File: core/aicr_device.sv */
// clock, reset, image loader and interrupt logic of the bridge
// How it works
// - test code 00 means normal operation
// - core select high enables internal core
// - preference pin high selects usb
// - shadow size high 16k, low 24k
// - system reset active low, held while low
// - copy image on power-on and switches
// - power-on image base from preference pin
// - cable switch: load finishes before reset ends
// - external flash preferred over internal rom
// - one interface active, first come wins
// - both connected at power-on: preference decides
// - cable power change raises shared interrupt
// - usb, 1394, manual select toggles interrupt
// - cable status readable in clock configuration
// - firmware switch reloads image under reset
// - gpio interrupts share the same line
// - gpio interrupts level or edge, polarity
// - gpio five drives usb remote wake-up
// - every shared line source wakes device
// - idle interface logic is powered down
// - bit one stops 1394 clock when usb
// - usb clock handling left to firmware
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
module aicr_device
    import aicr_pkg::*;
#(
    parameter int SMALL_BYTES = aicr_pkg::SRAM_SMALL,   // shorten for simulation
    parameter int LARGE_BYTES = aicr_pkg::SRAM_LARGE
)(
    input  wire logic        clk,
    input  wire logic        arst_n,
    aicr_if.dev              link,
    input  wire logic        usb_cable_power,
    input  wire logic        fw_cable_power,
    input  wire logic        manual_usb_select,
    input  wire logic        interface_preference_pin,
    input  wire logic        shadow_size_select,
    input  wire logic        internal_core_select,
    input  wire logic [1:0]  test_config,
    input  wire logic        flash_present,
    input  wire logic [5:0]  extra_gpio,
    input  wire logic [7:0]  store_data,
    output logic [15:0]      store_addr,
    output logic             store_from_flash,
    output logic             sram_we,
    output logic [14:0]      sram_addr,
    output logic [7:0]       sram_data,
    output logic             usb_power_down,
    output logic             fw_power_down,
    output logic             fw_clock_stop,
    output logic             usb_remote_wake,
    output logic             wake_request,
    output logic             core_enable,
    output logic             normal_mode
);
    import aicr_pkg::*;

    generate
        if (SMALL_BYTES < 1 || LARGE_BYTES < 1 || SMALL_BYTES > 32768 || LARGE_BYTES > 32768)
        begin : g_bad_size
            $error("aicr_device: shadow sizes must be 1..32768 bytes");
        end
    endgenerate

    // all state of the block
    typedef struct packed {
        logic [PIN_W-1:0] s1;           // first synchroniser stage
        logic [PIN_W-1:0] s2;           // second synchroniser stage
        logic [PIN_W-1:0] prev;         // last seen synchronised pins
        logic [1:0]       boot;         // strap settle counter
        aicr_load_t       st;           // loader state
        logic             active;       // 1 usb, 0 1394
        logic             stop_fw;      // firmware asked to stop 1394 clock
        logic             big;          // 24k image
        logic             src_flash;    // read from flash
        logic [14:0]      cnt;          // bytes copied
        logic             pend;         // cable change pending
        logic             missed;       // toggles while pending
        logic [17:0]      gcfg;         // gpio interrupt setup
        logic [5:0]       gsticky;      // gpio edge latches
        logic             rst_n;        // system reset out
        logic             sram_we;
        logic [14:0]      sram_addr;
        logic [7:0]       sram_data;
        logic [15:0]      store_addr;
        logic             usb_pd;
        logic             fw_pd;
        logic             clk_stop;
        logic             wake;
        logic             remote_wake;
        logic             core_en;
        logic             normal;
        logic             irq;
        logic [7:0]       clk_cfg;
        logic [5:0]       gpend;
    } aicr_dev_state_t;

    aicr_dev_state_t q;                 // registered state
    aicr_dev_state_t d;                 // next state

    // store address of a byte within the image of one interface
    function automatic logic [15:0] load_addr(input logic usb, input logic [14:0] idx);
        load_addr = (usb ? USB_IMAGE_BASE : FW_IMAGE_BASE) + {1'b0, idx};
    endfunction

    // next-state logic
    always_comb
    begin
        logic [PIN_W-1:0] s;            // synchronised pins
        logic [5:0]       lvl;          // gpio at active level
        logic [5:0]       plvl;         // same, one cycle ago
        logic [5:0]       en;
        logic [5:0]       edg;
        logic [5:0]       gack;
        logic             cable_ack;
        logic             toggle;
        logic             want;         // interface that should be active
        logic [14:0]      last;
        s         = q.s2;
        en        = q.gcfg[GC_EN+:GPIO_N];
        edg       = q.gcfg[GC_EDGE+:GPIO_N];
        lvl       = s[P_GPIO+:GPIO_N] ~^ q.gcfg[GC_POL+:GPIO_N];
        plvl      = q.prev[P_GPIO+:GPIO_N] ~^ q.gcfg[GC_POL+:GPIO_N];
        gack      = 6'h00;
        cable_ack = 1'b0;
        toggle    = 1'b0;
        want      = q.active;
        last      = q.big ? 15'(LARGE_BYTES - 1) : 15'(SMALL_BYTES - 1);
        d         = q;
        d.s1      = {extra_gpio, flash_present, test_config, internal_core_select,
                     shadow_size_select, interface_preference_pin, manual_usb_select,
                     fw_cable_power, usb_cable_power};
        d.s2      = q.s1;
        d.sram_we = 1'b0;
        // commands that are taken in any state
        if (link.cmd_wr && link.cmd_sel == CMD_GPIOCFG)
        begin
            d.gcfg = link.cmd_data[17:0];
        end
        if (link.cmd_wr && link.cmd_sel == CMD_ACK)
        begin
            cable_ack = link.cmd_data[ACK_CABLE];
            gack      = link.cmd_data[ACK_GPIO+:GPIO_N];
        end
        case (q.st)
            // wait for the synchronisers, then catch the straps
            LD_BOOT:
            begin
                if (q.boot == BOOT_WAIT)
                begin
                    want        = s[P_PREF];
                    d.src_flash = s[P_FLASH];
                    d.big       = !s[P_SHADOW];
                    d.prev      = s;
                end
                else
                begin
                    d.boot = q.boot + 2'h1;
                end
            end
            // running: watch cables and firmware
            LD_IDLE:
            begin
                d.prev = s;
                toggle = (s[P_USB] != q.prev[P_USB]) || (s[P_FW] != q.prev[P_FW])
                      || (s[P_MAN] != q.prev[P_MAN]);
                // first come: leave only when the active cable is gone
                if (q.active && !s[P_USB] && s[P_FW])
                begin
                    want = 1'b0;
                end
                else if (!q.active && !s[P_FW] && s[P_USB])
                begin
                    want = 1'b1;
                end
                if (link.cmd_wr && link.cmd_sel == CMD_CLKCFG)
                begin
                    want      = link.cmd_data[CC_ACTIVE];
                    d.stop_fw = link.cmd_data[CC_STOP_FW_CLK];
                end
            end
            // copy one byte a cycle with the core held in reset
            LD_RUN:
            begin
                d.prev      = s;
                toggle      = (s[P_USB] != q.prev[P_USB]) || (s[P_FW] != q.prev[P_FW])
                           || (s[P_MAN] != q.prev[P_MAN]);
                d.sram_we   = 1'b1;
                d.sram_addr = q.cnt;
                d.sram_data = store_data;
                if (q.cnt == last)
                begin
                    d.st    = LD_IDLE;
                    d.rst_n = 1'b1;
                end
                else
                begin
                    d.cnt        = q.cnt + 15'h0001;
                    d.store_addr = load_addr(q.active, q.cnt + 15'h0001);
                end
            end
            default:
            begin
                d.st = LD_BOOT;
            end
        endcase
        // start a copy at power-on or on a change of interface
        if ((q.st == LD_BOOT && q.boot == BOOT_WAIT) || (q.st == LD_IDLE && want != q.active))
        begin
            d.active     = want;
            d.big        = !s[P_SHADOW];
            d.st         = LD_RUN;
            d.cnt        = 15'h0000;
            d.rst_n      = 1'b0;
            d.store_addr = load_addr(want, 15'h0000);
        end
        if (!d.active)
        begin
            d.stop_fw = 1'b0;
        end
        // cable event: set wins over acknowledge
        d.missed = (q.missed && !cable_ack) || (toggle && q.pend && !cable_ack);
        d.pend   = (q.pend && !cable_ack) || toggle;
        d.gsticky = (q.gsticky & ~gack) | (lvl & ~plvl & edg & en
                    & {GPIO_N{q.st != LD_BOOT}});
        d.gpend   = en & ((edg & d.gsticky) | (~edg & lvl));
        // outputs, all from flip-flops
        d.irq         = d.pend || (|d.gpend);
        d.wake        = d.irq;
        d.remote_wake = lvl[GPIO_WAKE];
        d.usb_pd      = !d.active;
        d.fw_pd       = d.active;
        d.clk_stop    = d.active && d.stop_fw;
        d.core_en     = s[P_CORE];
        d.normal      = s[P_TEST+:2] == TEST_NORMAL;
        d.clk_cfg     = {d.st == LD_RUN, d.missed, d.pend, s[P_MAN],
                         s[P_FW], s[P_USB], d.stop_fw, d.active};
    end

    // state register, everything clears under reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // port wiring
    assign link.clk_cfg     = q.clk_cfg;
    assign link.gpio_pend   = q.gpend;
    assign link.irq         = q.irq;
    assign link.sys_rst_n   = q.rst_n;
    assign store_addr       = q.store_addr;
    assign store_from_flash = q.src_flash;
    assign sram_we          = q.sram_we;
    assign sram_addr        = q.sram_addr;
    assign sram_data        = q.sram_data;
    assign usb_power_down   = q.usb_pd;
    assign fw_power_down    = q.fw_pd;
    assign fw_clock_stop    = q.clk_stop;
    assign usb_remote_wake  = q.remote_wake;
    assign wake_request     = q.wake;
    assign core_enable      = q.core_en;
    assign normal_mode      = q.normal;
endmodule // aicr_device

/* File: core/aicr_if.sv */
// link between the clock and reset block and its firmware-side controller
interface aicr_if;
    logic        cmd_wr;        // one-cycle command strobe
    logic [1:0]  cmd_sel;       // which command
    logic [31:0] cmd_data;      // command payload
    logic [7:0]  clk_cfg;       // clock configuration readback
    logic [5:0]  gpio_pend;     // gpio interrupt status
    logic        irq;           // shared interrupt line
    logic        sys_rst_n;     // system reset to the core
    modport dev (input cmd_wr, cmd_sel, cmd_data, output clk_cfg, gpio_pend, irq, sys_rst_n);
    modport ctl (output cmd_wr, cmd_sel, cmd_data, input clk_cfg, gpio_pend, irq, sys_rst_n);
endinterface

/* File: core/aicr_pkg.sv */
// shared constants and types for the active interface clock and reset block
package aicr_pkg;
    // command selectors on the device link
    localparam logic [1:0]  CMD_CLKCFG      = 2'h0;     // clock configuration write
    localparam logic [1:0]  CMD_GPIOCFG     = 2'h1;     // extra gpio interrupt setup write
    localparam logic [1:0]  CMD_ACK         = 2'h2;     // acknowledge pending events
    // clock configuration register bit positions
    localparam int          CC_ACTIVE       = 0;        // 1 usb active, 0 1394 active
    localparam int          CC_STOP_FW_CLK  = 1;        // stop the 1394 phy clock
    localparam int          CC_USB_DET      = 2;        // usb cable power seen
    localparam int          CC_FW_DET       = 3;        // 1394 cable power seen
    localparam int          CC_MANUAL       = 4;        // manual usb select level
    localparam int          CC_PENDING      = 5;        // cable change event pending
    localparam int          CC_MISSED       = 6;        // further toggles while pending
    localparam int          CC_LOADING      = 7;        // image copy running
    // gpio setup word fields, six bits each
    localparam int          GC_EN           = 0;        // interrupt enable per pin
    localparam int          GC_EDGE         = 6;        // 1 edge, 0 level
    localparam int          GC_POL          = 12;       // 1 positive, 0 negative
    localparam int          GPIO_N          = 6;        // number of extra gpio pins
    localparam int          GPIO_WAKE       = 5;        // pin tied to remote wake-up
    // acknowledge word fields
    localparam int          ACK_CABLE       = 0;        // clears cable change event
    localparam int          ACK_GPIO        = 1;        // six bits of gpio edge clears
    // program store layout
    localparam logic [15:0] USB_IMAGE_BASE  = 16'h0000;
    localparam logic [15:0] FW_IMAGE_BASE   = 16'h8000;
    localparam int          SRAM_SMALL      = 16384;    // bytes with shadow size high
    localparam int          SRAM_LARGE      = 24576;    // bytes with shadow size low
    localparam logic [1:0]  TEST_NORMAL     = 2'h0;     // normal functional code
    localparam logic [1:0]  BOOT_WAIT       = 2'h3;     // cycles before straps are caught
    // apb register offsets of the controller
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_GPIO_CFG    = 8'h08;
    localparam logic [7:0]  OFS_ACK         = 8'h0C;
    localparam logic [7:0]  OFS_GPIO_PEND   = 8'h10;
    // pin vector positions in the device synchroniser
    localparam int          P_USB           = 0;
    localparam int          P_FW            = 1;
    localparam int          P_MAN           = 2;
    localparam int          P_PREF          = 3;
    localparam int          P_SHADOW        = 4;
    localparam int          P_CORE          = 5;
    localparam int          P_TEST          = 6;        // two bits
    localparam int          P_FLASH         = 8;
    localparam int          P_GPIO          = 9;        // six bits
    localparam int          PIN_W           = 15;
    // image loader states
    typedef enum logic [1:0] {
        LD_BOOT = 2'b00,
        LD_IDLE = 2'b01,
        LD_RUN  = 2'b10
    } aicr_load_t;
endpackage

/* File: tb/aicr_assertions.sv */
// link checks between the clock and reset block and its controller
module aicr_assertions (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        cmd_wr,
    input wire logic [1:0]  cmd_sel,
    input wire logic [31:0] cmd_data,
    input wire logic [7:0]  clk_cfg,
    input wire logic [5:0]  gpio_pend,
    input wire logic        irq,
    input wire logic        sys_rst_n
);
    import aicr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_irq_sources: assert property (irq == (clk_cfg[CC_PENDING] | (|gpio_pend)))
        else $error("shared line differs from sources");
    a_reset_in_load: assert property (clk_cfg[CC_LOADING] |-> !sys_rst_n)
        else $error("reset released mid load");
    a_load_ends: assert property ($rose(clk_cfg[CC_LOADING]) |-> ##[1:40] sys_rst_n)
        else $error("load never ends");
    a_active_loads: assert property ($changed(clk_cfg[CC_ACTIVE]) |-> clk_cfg[CC_LOADING])
        else $error("switch without load");
    a_toggle_pends: assert property (sys_rst_n && $changed(clk_cfg[4:2]) |-> clk_cfg[5])
        else $error("toggle not pending");
    a_missed_pending: assert property (clk_cfg[CC_MISSED] |-> clk_cfg[CC_PENDING])
        else $error("overrun without pending");
    a_stop_usb_only: assert property (clk_cfg[CC_STOP_FW_CLK] |-> clk_cfg[CC_ACTIVE])
        else $error("1394 clock stopped while active");
    a_write_switch: assert property (cmd_wr && cmd_sel == CMD_CLKCFG && sys_rst_n &&
        cmd_data[0] != clk_cfg[CC_ACTIVE] |=> clk_cfg[CC_LOADING])
        else $error("switch write did not load");
endmodule // aicr_assertions

/* File: tb/test_active_interface_clock_reset.sv */
// self-checking bench: device and controller joined by their link
module test_active_interface_clock_reset;
    timeunit 1ns;
    timeprecision 1ps;
    import aicr_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic usb_cable_power = 1'h1, fw_cable_power = 1'h0, manual_usb_select = 1'h0;
    logic interface_preference_pin = 1'h1, shadow_size_select = 1'h1;
    logic internal_core_select = 1'h1, flash_present = 1'h1;
    logic [1:0] test_config = 2'h0;
    logic [5:0] extra_gpio = 6'h0;
    logic [15:0] store_addr, img_base, img_at;
    logic [7:0] store_data, sram_data;
    logic [14:0] sram_addr;
    logic store_from_flash, sram_we, usb_power_down, fw_power_down, fw_clock_stop;
    logic usb_remote_wake, wake_request, core_enable, normal_mode;
    logic pready, pslverr, shared_irq_line, core_reset_n;
    int err_count = 0, comparisons = 0, we_cnt = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    // store answers at once with an address-derived byte
    assign store_data = store_addr[7:0] ^ store_addr[15:8];
    aicr_if link ();
    aicr_device #(.SMALL_BYTES(16), .LARGE_BYTES(24)) i_aicr_device (.clk, .arst_n, .link,
        .usb_cable_power, .fw_cable_power, .manual_usb_select, .interface_preference_pin,
        .shadow_size_select, .internal_core_select, .test_config, .flash_present, .extra_gpio,
        .store_data, .store_addr, .store_from_flash, .sram_we, .sram_addr, .sram_data,
        .usb_power_down, .fw_power_down, .fw_clock_stop, .usb_remote_wake, .wake_request,
        .core_enable, .normal_mode);
    aicr_ctl i_aicr_ctl (.clk, .arst_n, .link, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .shared_irq_line, .core_reset_n);
    aicr_assertions i_aicr_assertions (.clk, .arst_n, .cmd_wr(link.cmd_wr),
        .cmd_sel(link.cmd_sel), .cmd_data(link.cmd_data), .clk_cfg(link.clk_cfg),
        .gpio_pend(link.gpio_pend), .irq(link.irq), .sys_rst_n(link.sys_rst_n));
    // every shadow write carries the store byte of its own offset
    always @(posedge clk)
        if (sram_we === 1'h1)
        begin
            if (sram_addr === 15'h0)
                img_base = store_addr - 16'h1;
            we_cnt = (sram_addr === 15'h0) ? 1 : we_cnt + 1;
            img_at = img_base + {1'h0, sram_addr};
            chk("byte", {24'h0, img_at[7:0] ^ img_at[15:8]}, {24'h0, sram_data});
        end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // a wait that used up its bound ends the run
    task automatic bound(input int n);
        if (n >= 400)
        begin
            err_count++;
            conclude();
        end
    endtask
    // one apb transfer; e is the expected error answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1 && ++n < 400);
        rd = prdata;
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'h0;
        penable <= 1'h0;
        bound(n);
    endtask
    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (core_reset_n !== v && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        bound(n);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'h1;
        wait_rst(1'h1);
        chk("boot base", 32'h0, 32'(img_base));
        chk("boot bytes", 32'h10, we_cnt);
        chk("flash", 32'h1, 32'(store_from_flash));
        chk("core", 32'h1, 32'(core_enable));
        chk("normal", 32'h1, 32'(normal_mode));
        chk("1394 down", 32'h1, 32'(fw_power_down));
        apb(1'h0, OFS_STATUS, 32'h0, 1'h0);
        chk("status", 32'h5, 32'(rd[4:0]));
        apb(1'h1, OFS_ACK, 32'h1, 1'h0);
        fw_cable_power <= 1'h1;
        settle();
        chk("cable irq", 32'h1, 32'(shared_irq_line));
        manual_usb_select <= 1'h1;
        settle();
        apb(1'h0, OFS_STATUS, 32'h0, 1'h0);
        chk("overrun", 32'h7d, 32'(rd[6:0]));
        apb(1'h1, OFS_ACK, 32'h1, 1'h0);
        settle();
        chk("irq clear", 32'h0, 32'(shared_irq_line));
        $display("end cable");
        apb(1'h1, OFS_CTRL, 32'h3, 1'h0);
        settle();
        chk("clock stop", 32'h1, 32'(fw_clock_stop));
        apb(1'h1, OFS_STATUS, 32'h0, 1'h1);
        apb(1'h0, 8'h14, 32'h0, 1'h1);
        chk("unmapped", 32'h0, rd);
        apb(1'h1, OFS_CTRL, 32'h0, 1'h0);
        apb(1'h1, OFS_CTRL, 32'h1, 1'h1);
        chk("load reset", 32'h0, 32'(core_reset_n));
        wait_rst(1'h1);
        chk("1394 base", 32'h8000, 32'(img_base));
        chk("usb down", 32'h1, 32'(usb_power_down));
        chk("clock run", 32'h0, 32'(fw_clock_stop));
        $display("end switch");
        shadow_size_select <= 1'h0;
        fw_cable_power <= 1'h0;
        wait_rst(1'h0);
        wait_rst(1'h1);
        chk("auto base", 32'h0, 32'(img_base));
        chk("large bytes", 32'h18, we_cnt);
        apb(1'h1, OFS_ACK, 32'h1, 1'h0);
        $display("end auto");
        apb(1'h1, OFS_GPIO_CFG, 32'h0002_0820, 1'h0);
        extra_gpio[5] <= 1'h1;
        settle();
        chk("remote wake", 32'h1, 32'(usb_remote_wake));
        chk("wake", 32'h1, 32'(wake_request));
        extra_gpio[5] <= 1'h0;
        settle();
        apb(1'h0, OFS_GPIO_PEND, 32'h0, 1'h0);
        chk("edge latch", 32'h20, rd);
        chk("gpio irq", 32'h1, 32'(shared_irq_line));
        apb(1'h1, OFS_ACK, 32'h40, 1'h0);
        apb(1'h1, OFS_GPIO_CFG, 32'h1, 1'h0);
        settle();
        apb(1'h0, OFS_GPIO_PEND, 32'h0, 1'h0);
        chk("low level", 32'h1, rd);
        $display("end gpio");
        // other strap codes, then a second power-on with both cables present
        internal_core_select <= 1'h0;
        test_config <= 2'h1;
        settle();
        chk("core off", 32'h0, 32'(core_enable));
        chk("test mode", 32'h0, 32'(normal_mode));
        arst_n <= 1'h0;
        fw_cable_power <= 1'h1;
        interface_preference_pin <= 1'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        wait_rst(1'h1);
        chk("both base", 32'h8000, 32'(img_base));
        chk("both bytes", 32'h18, we_cnt);
        chk("both usb down", 32'h1, 32'(usb_power_down));
        $display("end straps");
        conclude();
    end
endmodule // test_active_interface_clock_reset
